/* File: hdl/clock_select_pkg.sv */
// Shared constants and types for the system clock select guard
package clock_select_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET    = 8'h00;
  localparam logic [7:0] STATUS_OFFSET  = 8'h04;
  localparam logic [7:0] SCRATCH_OFFSET = 8'h08;
  localparam int         ADDR_WIDTH     = 8;

  // ----------------------------------------------------------------
  // Control register fields and values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET   = 8'hA0;
  localparam logic [7:0] UNLOCK_FIRST = 8'hE7;
  localparam logic [7:0] UNLOCK_SECOND = 8'h18;

  localparam logic [2:0] SRC_PREC_FAST = 3'h0;
  localparam logic [2:0] SRC_PREC_SLOW = 3'h1;
  localparam logic [2:0] SRC_CRYSTAL   = 3'h2;
  localparam logic [2:0] SRC_SLOW_OSC  = 3'h3;
  localparam logic [2:0] SRC_EXT_PIN   = 3'h4;

  // Status register bit positions
  localparam int ST_PRIM_PEND  = 0;
  localparam int ST_SLOW_PEND  = 1;
  localparam int ST_FALLBACK   = 2;
  localparam int ST_SLOW_FAIL  = 3;
  localparam int ST_HALTED     = 4;
  localparam int ST_LOCK_LSB   = 5;
  localparam int ST_ACTIVE_LSB = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS        = 4;
  localparam int PRIMARY_FAIL_PERIOD_NS = 1000000;
  localparam int PRIMARY_FAIL_CYCLES    = PRIMARY_FAIL_PERIOD_NS / CLOCK_PERIOD_NS;
  localparam int SLOW_FAIL_CYCLES       = 8004;
  localparam int TIMER_WIDTH            = 18;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       precisionEn;
    logic       crystalEn;
    logic       slowOscEn;
    logic       primaryDetectEn;
    logic       slowDetectEn;
    logic [2:0] sourceSel;
  } clockCtrl_type;

  typedef enum logic [1:0] {
    LOCKED    = 2'b00,
    GOT_FIRST = 2'b01,
    UNLOCKED  = 2'b11
  } unlock_type;

endpackage

/* File: hdl/gap_timer.sv */
// Counts advance steps since the last restart and pulses each time the count wraps at the limit
`timescale 1ns/1ps
module gap_timer
  import clock_select_pkg::*;
#(
  parameter int LIMIT = 8004
)
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic advance,
  input  wire logic restart,
  output logic      expired
);

  localparam logic [TIMER_WIDTH-1:0] LAST = TIMER_WIDTH'(LIMIT - 1);

  logic [TIMER_WIDTH-1:0] count_q;

  // A restart always wins, so a live clock never lets the count reach the limit
  always_ff @(posedge clock)
  begin
    if (rst || !enable || restart)
      count_q <= '0;
    else if (advance && count_q == LAST)
      count_q <= '0;
    else if (advance)
      count_q <= count_q + TIMER_WIDTH'(1);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      expired <= 1'b0;
    else
      expired <= enable && !restart && advance && count_q == LAST;
  end

endmodule

/* File: hdl/system_clock_select_guard.sv */
// System clock source selection with write unlock and clock failure guards
//
// Function
// - Control register unlocks only after writes E7h then 18h, in that order.
// - Next write after unlock updates the register and relocks it at once.
// - Writes outside the correct unlock order leave the register unchanged.
// - Unlock steps need not be adjacent; other register accesses keep state.
// - Detection may be re-enabled any time after a successful source write.
// - Precision oscillator enabled out of reset and stays on until cleared.
// - Primary failure raises an event and forces the supervision oscillator.
// - Fallback happens only while the supervision oscillator is enabled.
// - Primary failure flagged when system clock falls below about 1 kHz.
// - Supervision oscillator failure raises an event, source unchanged.
// - After supervision failure, primary failure detection stops working.
// - Supervision failure after 8004 system clocks with no supervision edge.
// - No detection and no working source: halt until power-on reset.
// - Precision oscillator selectable at 5.53 MHz or 32.8 kHz.
// - Select codes: 000 fast, 001 slow, 010 crystal, 011 supervision, 100 pin.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module system_clock_select_guard
  import clock_select_pkg::*;
#(
  parameter int PRIMARY_LIMIT = PRIMARY_FAIL_CYCLES,
  parameter int SLOW_LIMIT    = SLOW_FAIL_CYCLES
)
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic [ADDR_WIDTH-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [ADDR_WIDTH-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire logic                  sysClockTick,
  input  wire logic                  slowOscTick,
  input  wire logic                  primaryFailAck,
  input  wire logic                  slowFailAck,
  output logic                       primaryFailPending,
  output logic                       slowFailPending,
  output clockCtrl_type              oscEnables,
  output logic [2:0]                 activeSource,
  output logic                       halted
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic [1:0] decodeSlot(input logic [ADDR_WIDTH-1:0] addr);
    logic [1:0] slot;
    slot = 2'h3;
    if (addr == CTRL_OFFSET)
      slot = 2'h0;
    else if (addr == STATUS_OFFSET)
      slot = 2'h1;
    else if (addr == SCRATCH_OFFSET)
      slot = 2'h2;
    return slot;
  endfunction

  // Every select code that has a live oscillator behind it
  function automatic logic sourceUsable(input clockCtrl_type c, input logic [2:0] sel);
    logic ok;
    ok = 1'b0;
    case (sel)
      SRC_PREC_FAST, SRC_PREC_SLOW: ok = c.precisionEn;
      SRC_CRYSTAL:                  ok = c.crystalEn;
      SRC_SLOW_OSC:                 ok = c.slowOscEn;
      SRC_EXT_PIN:                  ok = 1'b1;
      default:                      ok = 1'b0;
    endcase
    return ok;
  endfunction

  clockCtrl_type ctrl_q;
  unlock_type    lock_q;
  logic [31:0]   scratch_q;
  logic          fallback_q;
  logic          slowFailed_q;
  logic          writeFire;
  logic [1:0]    writeSlot;
  logic          ctrlWrite;
  logic          primaryExpired;
  logic          slowExpired;
  logic          primaryDetectLive;
  logic          haltNow;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  // Address and data are taken together so neither is accepted without the other
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      awready <= 1'b0;
      wready  <= 1'b0;
    end
    else
    begin
      awready <= awvalid && wvalid && !awready && !bvalid;
      wready  <= awvalid && wvalid && !awready && !bvalid;
    end
  end

  assign writeFire = awready && awvalid && wready && wvalid;
  assign writeSlot = decodeSlot(awaddr);
  assign ctrlWrite = writeFire && writeSlot == 2'h0 && wstrb[0];

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end
    else if (writeFire)
    begin
      bvalid <= 1'b1;
      bresp  <= (writeSlot == 2'h3) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      scratch_q <= 32'h00000000;
    else if (writeFire && writeSlot == 2'h2)
    begin
      for (int b = 0; b < 4; b++)
        if (wstrb[b])
          scratch_q[b*8 +: 8] <= wdata[b*8 +: 8];
    end
  end

  // ----------------------------------------------------------------
  // Unlock sequence
  // ----------------------------------------------------------------
  // Only writes to the control word move this machine; other slots leave it alone
  always_ff @(posedge clock)
  begin
    if (rst)
      lock_q <= LOCKED;
    else if (ctrlWrite)
    begin
      case (lock_q)
        LOCKED:    lock_q <= (wdata[7:0] == UNLOCK_FIRST) ? GOT_FIRST : LOCKED;
        GOT_FIRST: lock_q <= (wdata[7:0] == UNLOCK_SECOND) ? UNLOCKED :
                             (wdata[7:0] == UNLOCK_FIRST) ? GOT_FIRST : LOCKED;
        UNLOCKED:  lock_q <= LOCKED;
        default:   lock_q <= LOCKED;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      ctrl_q <= clockCtrl_type'(CTRL_RESET);
    else if (ctrlWrite && lock_q == UNLOCKED)
      ctrl_q <= clockCtrl_type'(wdata[7:0]);
  end

  // ----------------------------------------------------------------
  // Failure detection
  // ----------------------------------------------------------------
  // Primary detector goes blind once the supervision clock is gone or a fallback to it is in force
  assign primaryDetectLive = ctrl_q.primaryDetectEn && !slowFailed_q && !fallback_q;

  gap_timer #(
    .LIMIT   (PRIMARY_LIMIT)
  ) primaryTimer (
    .clock   (clock),
    .rst     (rst),
    .enable  (primaryDetectLive),
    .advance (1'b1),
    .restart (sysClockTick),
    .expired (primaryExpired)
  );

  gap_timer #(
    .LIMIT   (SLOW_LIMIT)
  ) slowTimer (
    .clock   (clock),
    .rst     (rst),
    .enable  (ctrl_q.slowDetectEn && !slowFailed_q),
    .advance (sysClockTick),
    .restart (slowOscTick),
    .expired (slowExpired)
  );

  always_ff @(posedge clock)
  begin
    if (rst)
      slowFailed_q <= 1'b0;
    else if (slowExpired)
      slowFailed_q <= 1'b1;
  end

  // Fallback holds until software commits a fresh source selection
  always_ff @(posedge clock)
  begin
    if (rst)
      fallback_q <= 1'b0;
    else if (primaryExpired && ctrl_q.slowOscEn)
      fallback_q <= 1'b1;
    else if (ctrlWrite && lock_q == UNLOCKED)
      fallback_q <= 1'b0;
  end

  // Set wins over acknowledge so an event in the ack cycle is kept
  always_ff @(posedge clock)
  begin
    if (rst)
      primaryFailPending <= 1'b0;
    else if (primaryExpired)
      primaryFailPending <= 1'b1;
    else if (primaryFailAck)
      primaryFailPending <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      slowFailPending <= 1'b0;
    else if (slowExpired)
      slowFailPending <= 1'b1;
    else if (slowFailAck)
      slowFailPending <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Source outputs and halt
  // ----------------------------------------------------------------
  // A supervision failure never moves the source, only a primary fallback does
  always_ff @(posedge clock)
  begin
    if (rst)
      activeSource <= SRC_PREC_FAST;
    else if (fallback_q || (primaryExpired && ctrl_q.slowOscEn))
      activeSource <= SRC_SLOW_OSC;
    else
      activeSource <= ctrl_q.sourceSel;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      oscEnables <= clockCtrl_type'(CTRL_RESET);
    else
      oscEnables <= ctrl_q;
  end

  assign haltNow = !sourceUsable(ctrl_q, activeSource) &&
                   !(primaryDetectLive && ctrl_q.slowOscEn);

  // Sticky: only the reset line, which stands for power-on, brings it back
  always_ff @(posedge clock)
  begin
    if (rst)
      halted <= 1'b0;
    else if (haltNow)
      halted <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
      arready <= 1'b0;
    else
      arready <= arvalid && !arready && !rvalid;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= RESP_OKAY;
    end
    else if (arready && arvalid)
    begin
      rvalid <= 1'b1;
      rresp  <= RESP_OKAY;
      rdata  <= 32'h00000000;
      case (decodeSlot(araddr))
        2'h0: rdata[7:0] <= ctrl_q;
        2'h1:
        begin
          rdata[ST_PRIM_PEND]                 <= primaryFailPending;
          rdata[ST_SLOW_PEND]                 <= slowFailPending;
          rdata[ST_FALLBACK]                  <= fallback_q;
          rdata[ST_SLOW_FAIL]                 <= slowFailed_q;
          rdata[ST_HALTED]                    <= halted;
          rdata[ST_LOCK_LSB +: 2]             <= lock_q;
          rdata[ST_ACTIVE_LSB +: 3]           <= activeSource;
        end
        2'h2: rdata <= scratch_q;
        default: rresp <= RESP_SLVERR;
      endcase
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_unlock_order;
    ctrlWrite && lock_q == LOCKED && wdata[7:0] != UNLOCK_FIRST |=> lock_q == LOCKED;
  endproperty
  a_unlock_order: assert property (p_unlock_order) else $error("Lock advanced on wrong first key");

  property p_update_relock;
    ctrlWrite && lock_q == UNLOCKED |=> lock_q == LOCKED && ctrl_q == clockCtrl_type'($past(wdata[7:0]));
  endproperty
  a_update_relock: assert property (p_update_relock) else $error("Unlocked write did not land or relock");

  property p_locked_hold;
    lock_q != UNLOCKED |=> $stable(ctrl_q);
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("Control changed while locked");

  property p_other_access_keeps_lock;
    !ctrlWrite |=> $stable(lock_q);
  endproperty
  a_other_access_keeps_lock: assert property (p_other_access_keeps_lock) else $error("Lock state lost");

  property p_fallback_source;
    primaryExpired && ctrl_q.slowOscEn |=> activeSource == SRC_SLOW_OSC && primaryFailPending;
  endproperty
  a_fallback_source: assert property (p_fallback_source) else $error("Primary failure did not fall back");

  property p_no_fallback_without_slow;
    primaryExpired && !ctrl_q.slowOscEn && !fallback_q |=> !fallback_q;
  endproperty
  a_no_fallback_without_slow: assert property (p_no_fallback_without_slow) else $error("Fallback without slow osc");

  property p_slow_fail_keeps_source;
    slowExpired && !fallback_q && !primaryExpired |=> ##1 activeSource == $past(ctrl_q.sourceSel);
  endproperty
  a_slow_fail_keeps_source: assert property (p_slow_fail_keeps_source) else $error("Slow failure moved source");

  property p_primary_blind;
    slowFailed_q && $past(slowFailed_q) |-> !primaryExpired;
  endproperty
  a_primary_blind: assert property (p_primary_blind) else $error("Primary detector ran after slow failure");

  property p_pending_held;
    primaryFailPending && !primaryFailAck |=> primaryFailPending;
  endproperty
  a_pending_held: assert property (p_pending_held) else $error("Pending flag dropped without ack");

  property p_halt_sticky;
    halted |=> halted [*8];
  endproperty
  a_halt_sticky: assert property (p_halt_sticky) else $error("Halt released without reset");

  c_full_unlock:   cover property (ctrlWrite && lock_q == UNLOCKED);
  c_fallback:      cover property (primaryExpired && ctrl_q.slowOscEn);
  c_slow_failure:  cover property (slowExpired);
  c_halt:          cover property (haltNow);

endmodule

/* File: verif/osc_partner_model.sv */
// Oscillator and interrupt-logic model on the far side of the clock select guard
`timescale 1ns/1ps
module osc_partner_model
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic sysRun,
  input  wire logic slowRun,
  input  wire logic ackOn,
  input  wire logic primaryFailPending,
  input  wire logic slowFailPending,
  output logic      sysClockTick,
  output logic      slowOscTick,
  output logic      primaryFailAck,
  output logic      slowFailAck
);
  // ----------------------------------------------------------------
  // Oscillators
  // ----------------------------------------------------------------
  logic [1:0] divQ;

  always_ff @(posedge clock)
  begin
    if (rst)
      divQ <= 2'h0;
    else
      divQ <= divQ + 2'h1;
  end

  // A dead oscillator stays flat, so the guard sees no edge at all
  assign sysClockTick = sysRun;
  assign slowOscTick  = slowRun && (divQ == 2'h3);

  // ----------------------------------------------------------------
  // Interrupt logic: acknowledges only when told, so pendings can be seen held
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      primaryFailAck <= 1'b0;
      slowFailAck    <= 1'b0;
    end
    else
    begin
      primaryFailAck <= ackOn & primaryFailPending;
      slowFailAck    <= ackOn & slowFailPending;
    end
  end
endmodule

/* File: verif/system_clock_select_guard_tb_top.sv */
// Self-checking bench for the system clock select guard
`timescale 1ns/1ps
module system_clock_select_guard_tb_top
  import clock_select_pkg::*;
();
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int PLIM = 40;
  localparam int SLIM = 12;
  localparam int XTAL_WAIT = 1000; // Clocks waited after the crystal is enabled, before the source switches
  logic                  clock = 1'b0;
  logic                  rst = 1'b1;
  logic [ADDR_WIDTH-1:0] awaddr = '0;
  logic [ADDR_WIDTH-1:0] araddr = '0;
  logic [31:0]           wdata = '0;
  logic                  awvalid = 1'b0;
  logic                  wvalid = 1'b0;
  logic                  bready = 1'b0;
  logic                  arvalid = 1'b0;
  logic                  rready = 1'b0;
  logic                  sysRun = 1'b1;
  logic                  slowRun = 1'b1;
  logic                  ackOn = 1'b0;
  logic                  awready, wready, bvalid, arready, rvalid;
  logic [1:0]            bresp, rresp;
  logic [31:0]           rdata;
  logic                  sysClockTick, slowOscTick, primaryFailAck, slowFailAck;
  logic                  primaryFailPending, slowFailPending, halted;
  clockCtrl_type         oscEnables;
  logic [2:0]            activeSource;
  int                    fail_count = 0;
  int                    tests_run = 0;
  int                    cycles = 0;

  always #2 clock = ~clock;

  system_clock_select_guard #(.PRIMARY_LIMIT(PLIM), .SLOW_LIMIT(SLIM)) i_dut
  (
    .clock(clock), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sysClockTick(sysClockTick), .slowOscTick(slowOscTick),
    .primaryFailAck(primaryFailAck), .slowFailAck(slowFailAck),
    .primaryFailPending(primaryFailPending), .slowFailPending(slowFailPending),
    .oscEnables(oscEnables), .activeSource(activeSource), .halted(halted)
  );

  osc_partner_model i_partner
  (
    .clock(clock), .rst(rst), .sysRun(sysRun), .slowRun(slowRun), .ackOn(ackOn),
    .primaryFailPending(primaryFailPending), .slowFailPending(slowFailPending),
    .sysClockTick(sysClockTick), .slowOscTick(slowOscTick),
    .primaryFailAck(primaryFailAck), .slowFailAck(slowFailAck)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Handshake waits are unbounded; the cycle ceiling below ends a hang

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do @(negedge clock); while (awready !== 1'b1);
    @(posedge clock);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    bready  <= 1'b1;
    do @(negedge clock); while (bvalid !== 1'b1);
    check("bresp", {30'h0, bresp}, {30'h0, er});
    @(posedge clock);
    bready <= 1'b0;
  endtask

  task automatic readCheck(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(negedge clock); while (arready !== 1'b1);
    @(posedge clock);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(negedge clock); while (rvalid !== 1'b1);
    check("rdata", rdata, exp);
    check("rresp", {30'h0, rresp}, {30'h0, er});
    @(posedge clock);
    rready <= 1'b0;
  endtask

  task automatic ctrlWrite(input logic [7:0] v);
    axiWrite(CTRL_OFFSET, {24'h0, v}, RESP_OKAY);
  endtask

  task automatic unlockSet(input logic [7:0] v);
    ctrlWrite(UNLOCK_FIRST);
    ctrlWrite(UNLOCK_SECOND);
    ctrlWrite(v);
  endtask

  task automatic doReset();
    @(posedge clock);
    rst     <= 1'b1;
    sysRun  <= 1'b1;
    slowRun <= 1'b1;
    ackOn   <= 1'b0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic tUnlock();
    check("enables", {24'h0, oscEnables}, 32'hA0);
    readCheck(CTRL_OFFSET, 32'hA0, RESP_OKAY);
    ctrlWrite(UNLOCK_SECOND);
    readCheck(STATUS_OFFSET, 32'h0, RESP_OKAY);
    ctrlWrite(UNLOCK_FIRST);
    readCheck(STATUS_OFFSET, 32'h20, RESP_OKAY);
    axiWrite(SCRATCH_OFFSET, 32'h5A5A_C3C3, RESP_OKAY);
    readCheck(SCRATCH_OFFSET, 32'h5A5A_C3C3, RESP_OKAY);
    ctrlWrite(UNLOCK_SECOND);
    readCheck(STATUS_OFFSET, 32'h60, RESP_OKAY);
    ctrlWrite(8'hA4);
    readCheck(CTRL_OFFSET, 32'hA4, RESP_OKAY);
    readCheck(STATUS_OFFSET, 32'h400, RESP_OKAY);
    ctrlWrite(8'hA0);
    readCheck(CTRL_OFFSET, 32'hA4, RESP_OKAY);
    ctrlWrite(UNLOCK_FIRST);
    ctrlWrite(8'h55);
    ctrlWrite(8'hA0);
    readCheck(CTRL_OFFSET, 32'hA4, RESP_OKAY);
    ctrlWrite(UNLOCK_FIRST);
    ctrlWrite(UNLOCK_FIRST);
    readCheck(STATUS_OFFSET, 32'h420, RESP_OKAY);
    unlockSet(8'hA0);
    readCheck(CTRL_OFFSET, 32'hA0, RESP_OKAY);
    readCheck(8'h0C, 32'h0, RESP_SLVERR);
    axiWrite(8'h10, 32'h1, RESP_SLVERR);
  endtask

  // Detectors stay off across every switch pin clock is live in the model
  task automatic tSelect();
    logic [7:0] v;
    unlockSet(8'hE0);
    repeat (XTAL_WAIT) @(posedge clock);
    for (int c = 0; c < 5; c++)
    begin
      v = 8'hE0 | 8'(c);
      unlockSet(v);
      @(posedge clock);
      check("source", {29'h0, activeSource}, 32'(c));
      check("enables", {24'h0, oscEnables}, {24'h0, v});
    end
  endtask

  task automatic tPrimary(input logic [7:0] v, input logic [2:0] src);
    doReset();
    unlockSet(8'hA0);
    unlockSet(v);
    @(posedge clock);
    sysRun <= 1'b0;
    repeat (PLIM - 4) @(posedge clock);
    check("early primary", {31'h0, primaryFailPending}, 32'h0);
    for (int n = 0; n < 12 && primaryFailPending !== 1'b1; n++)
      @(negedge clock);
    check("primary pend", {31'h0, primaryFailPending}, 32'h1);
    repeat (2) @(posedge clock);
    check("fallback", {29'h0, activeSource}, {29'h0, src});
    repeat (10) @(posedge clock);
    check("held", {31'h0, primaryFailPending}, 32'h1);
    ackOn <= 1'b1;
    repeat (4) @(posedge clock);
    check("acked", {31'h0, primaryFailPending}, 32'h0);
  endtask

  task automatic tSlow();
    doReset();
    unlockSet(8'hA8);
    @(posedge clock);
    slowRun <= 1'b0;
    repeat (SLIM - 4) @(posedge clock);
    check("early slow", {31'h0, slowFailPending}, 32'h0);
    for (int n = 0; n < 12 && slowFailPending !== 1'b1; n++)
      @(negedge clock);
    check("slow pend", {31'h0, slowFailPending}, 32'h1);
    check("source kept", {29'h0, activeSource}, 32'h0);
    unlockSet(8'hB0);
    @(posedge clock);
    sysRun <= 1'b0;
    repeat (PLIM + 20) @(posedge clock);
    check("no primary", {31'h0, primaryFailPending}, 32'h0);
  endtask

  task automatic tHalt();
    doReset();
    unlockSet(8'h20);
    repeat (3) @(posedge clock);
    check("halted", {31'h0, halted}, 32'h1);
    unlockSet(8'hA0);
    check("still halted", {31'h0, halted}, 32'h1);
    doReset();
    @(negedge clock);
    check("recovered", {31'h0, halted}, 32'h0);
    unlockSet(8'hA5);
    repeat (3) @(posedge clock);
    check("reserved halts", {31'h0, halted}, 32'h1);
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      test_done();
    end
  end

  initial
  begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    tUnlock();
    tSelect();
    tPrimary(8'hB0, SRC_SLOW_OSC);
    tPrimary(8'h90, SRC_PREC_FAST);
    tSlow();
    tHalt();
    test_done();
  end
endmodule
